// >>> tcc_channel.sv
// Operation
// - Clearing the count run bit stops the counter and zeroes it.
// - Counter overflow raises the match/overflow interrupt request.
// - Two compare registers; each signals a match when equal to the counter.
// - Each compare register has a buffer; buffering off after reset, enable bit selects.
// - With buffering on and running, buffers load on compare 1 match.
// - While stopped, compare writes take effect at once.
// - A two-bit field picks when captures 0 and 1 latch the counter.
// - Select 11: trigger rising edge captures 0, falling edge captures 1.
// - Writing 0 to the soft capture bit copies the counter into capture 0.
// - Reading the snapshot register returns the current count, apart from captures.
// - Any compare match raises the match/overflow interrupt request.
// - Toggle flip-flop inverts on matches and captures, each source separately enabled.
// - Force field write: 00 inverts, 01 sets, 10 clears the flip-flop.
// - Flip-flop level is undefined after reset until software forces it; the code resets it to 0.
// - Flip-flop drives the output pin once the pin function is enabled.
// - Each capture latch raises its own capture interrupt request.
// - Event counting on external input 0 counts its rising edges.
// - Slave with sync bit set starts with its group master, no run bits.
// - Pulse polarity is set by the flip-flop's initial forced state.
// - Clear-on-match resets the counter on compare 1 match; else free-running.
// - Count source selects divide 1, 4, 16 taps or external input 0.
// - Flags set even when masked; only unmasked ones interrupt; status read clears.
`timescale 1ns/100ps
`include "tcc_consts.svh"

module tcc_channel
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input tcc_bus_req_t bus_req,
  output logic [31:0] rd_data,
  // Board-side inputs
  input wire logic external_input_0,
  input wire logic external_input_1,
  input wire logic neighbour_flipflop_output,
  // Group start from the master channel's run output
  input wire logic master_run_in,
  // Outputs
  output logic timer_output_pin,
  output logic run_out,
  output logic match_overflow_irq,
  output logic capture0_irq,
  output logic capture1_irq
);

  tcc_state_t s_reg;
  tcc_state_t s_next;

  logic run_now;
  logic tick;
  logic match0;
  logic match1;
  logic ovf;
  logic cap0_ev;
  logic cap1_ev;
  logic soft_cap;
  logic wr_cmp0;
  logic wr_cmp1;
  logic [4:0] events;
  logic [3:0] tog_src;

  function automatic logic rise(input logic prev, input logic cur);
    rise = !prev && cur;
  endfunction : rise

  function automatic logic hit(input tcc_bus_req_t req, input logic [7:0] ofs, input logic is_wr);
    hit = (req.addr == ofs) && (is_wr ? req.wr : req.rd);
  endfunction : hit

  // A slave in a sync group follows the master's run level in the same cycle
  assign run_now = s_reg.sync ? master_run_in : s_reg.running;

  always_comb
  begin
    s_next = s_reg;

    // Prescaler taps; held clear while stopped so group members stay aligned
    s_next.pre = run_now ? s_reg.pre + 4'h1 : 4'h0;
    unique case (s_reg.src)
      TCC_SRC_EXT0: tick = rise(s_reg.in0_q, external_input_0);
      TCC_SRC_DIV1: tick = 1'b1;
      TCC_SRC_DIV4: tick = (s_reg.pre[1:0] == 2'h3);
      TCC_SRC_DIV16: tick = (s_reg.pre == 4'hF);
    endcase

    match0 = run_now && tick && (s_reg.cnt == s_reg.cmp0);
    match1 = run_now && tick && (s_reg.cnt == s_reg.cmp1);
    ovf = run_now && tick && (s_reg.cnt == `TCC_CNT_MAX) && !(s_reg.cle && match1);

    if (!run_now)
      s_next.cnt = `TCC_RST_COUNT;
    else if (s_reg.cle && match1)
      s_next.cnt = `TCC_RST_COUNT;
    else if (tick)
      s_next.cnt = s_reg.cnt + 16'h0001;

    // Capture triggers
    soft_cap = hit(bus_req, `TCC_OFS_MODE, 1'b1) && !bus_req.wdata[`TCC_MODE_SOFTCAP_BIT];
    cap0_ev = soft_cap;
    cap1_ev = 1'b0;
    unique case (s_reg.cpm)
      TCC_CPM_OFF:
      begin
        cap0_ev = soft_cap;
      end
      TCC_CPM_IN0_IN1:
      begin
        cap0_ev = soft_cap || rise(s_reg.in0_q, external_input_0);
        cap1_ev = rise(s_reg.in1_q, external_input_1);
      end
      TCC_CPM_IN0_BOTH:
      begin
        cap0_ev = soft_cap || rise(s_reg.in0_q, external_input_0);
        cap1_ev = rise(external_input_0, s_reg.in0_q);
      end
      TCC_CPM_NEIGHBOUR:
      begin
        cap0_ev = soft_cap || rise(s_reg.nb_q, neighbour_flipflop_output);
        cap1_ev = rise(neighbour_flipflop_output, s_reg.nb_q);
      end
    endcase
    if (cap0_ev)
      s_next.cap0 = s_reg.cnt;
    if (cap1_ev)
      s_next.cap1 = s_reg.cnt;
    s_next.in0_q = external_input_0;
    s_next.in1_q = external_input_1;
    s_next.nb_q = neighbour_flipflop_output;

    // Compare registers: buffer only while running with buffering on
    wr_cmp0 = hit(bus_req, `TCC_OFS_CMP0, 1'b1);
    wr_cmp1 = hit(bus_req, `TCC_OFS_CMP1, 1'b1);
    if (s_reg.dbe && run_now && match1)
    begin
      s_next.cmp0 = s_reg.buf0;
      s_next.cmp1 = s_reg.buf1;
    end
    if (wr_cmp0)
    begin
      s_next.buf0 = bus_req.wdata[15:0];
      if (!(s_reg.dbe && run_now))
        s_next.cmp0 = bus_req.wdata[15:0];
    end
    if (wr_cmp1)
    begin
      s_next.buf1 = bus_req.wdata[15:0];
      if (!(s_reg.dbe && run_now))
        s_next.cmp1 = bus_req.wdata[15:0];
    end

    // Toggle flip-flop; simultaneous sources cancel pairwise
    tog_src = {cap1_ev, cap0_ev, match1, match0};
    s_next.ff = s_reg.ff ^ (^(tog_src & s_reg.ten));
    if (hit(bus_req, `TCC_OFS_FFCR, 1'b1))
    begin
      s_next.ten = bus_req.wdata[`TCC_FFCR_TEN_LSB +: 4];
      unique case (tcc_force_t'(bus_req.wdata[`TCC_FFCR_FORCE_LSB +: 2]))
        TCC_FF_INVERT: s_next.ff = !s_reg.ff;
        TCC_FF_SET: s_next.ff = 1'b1;
        TCC_FF_CLEAR: s_next.ff = 1'b0;
        TCC_FF_KEEP: s_next.ff = s_next.ff;
      endcase
    end

    // Control writes
    if (hit(bus_req, `TCC_OFS_RUN, 1'b1))
    begin
      s_next.count_run = bus_req.wdata[`TCC_RUN_COUNT_BIT];
      s_next.pre_run = bus_req.wdata[`TCC_RUN_PRE_BIT];
    end
    s_next.running = s_next.count_run && s_next.pre_run;
    if (hit(bus_req, `TCC_OFS_CTRL, 1'b1))
    begin
      s_next.dbe = bus_req.wdata[`TCC_CTRL_DBE_BIT];
      s_next.sync = bus_req.wdata[`TCC_CTRL_SYNC_BIT];
      s_next.oe = bus_req.wdata[`TCC_CTRL_OE_BIT];
    end
    if (hit(bus_req, `TCC_OFS_MODE, 1'b1))
    begin
      s_next.src = tcc_src_t'(bus_req.wdata[`TCC_MODE_SRC_LSB +: 2]);
      s_next.cle = bus_req.wdata[`TCC_MODE_CLE_BIT];
      s_next.cpm = tcc_cpm_t'(bus_req.wdata[`TCC_MODE_CPM_LSB +: 2]);
    end
    if (hit(bus_req, `TCC_OFS_MASK, 1'b1))
      s_next.mask = bus_req.wdata[4:0];

    // Status: a read clears, but an event in the same cycle survives
    events = {cap1_ev, cap0_ev, ovf, match1, match0};
    s_next.st = (hit(bus_req, `TCC_OFS_STATUS, 1'b0) ? 5'h00 : s_reg.st) | events;
    s_next.mo_irq = |(s_next.st[2:0] & ~s_next.mask[2:0]);
    s_next.c0_irq = s_next.st[`TCC_ST_CAP0] && !s_next.mask[`TCC_ST_CAP0];
    s_next.c1_irq = s_next.st[`TCC_ST_CAP1] && !s_next.mask[`TCC_ST_CAP1];

    // Pin stays low until the pin function is enabled
    s_next.pin = s_next.ff && s_next.oe;

    // Read data stands one cycle, zero otherwise
    s_next.rdata = 32'h00000000;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `TCC_OFS_RUN:
          s_next.rdata = 32'(s_reg.count_run) | (32'(s_reg.pre_run) << `TCC_RUN_PRE_BIT);
        `TCC_OFS_CTRL:
          s_next.rdata = {29'h0, s_reg.oe, s_reg.sync, s_reg.dbe};
        `TCC_OFS_MODE:
          s_next.rdata = {26'h0, 1'b1, s_reg.cpm, s_reg.cle, s_reg.src};
        `TCC_OFS_FFCR:
          s_next.rdata = {26'h0, s_reg.ten, 2'h3};
        `TCC_OFS_STATUS:
          s_next.rdata = {27'h0, s_reg.st};
        `TCC_OFS_MASK:
          s_next.rdata = {27'h0, s_reg.mask};
        `TCC_OFS_SNAP:
        begin
          s_next.snap = s_reg.cnt;
          s_next.rdata = {16'h0, s_reg.cnt};
        end
        `TCC_OFS_CMP0:
          s_next.rdata = {16'h0, s_reg.cmp0};
        `TCC_OFS_CMP1:
          s_next.rdata = {16'h0, s_reg.cmp1};
        `TCC_OFS_CAP0:
          s_next.rdata = {16'h0, s_reg.cap0};
        `TCC_OFS_CAP1:
          s_next.rdata = {16'h0, s_reg.cap1};
        default:
          s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // The flip-flop resets to 0 only to keep simulation clean; software must force it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.mask <= `TCC_RST_MASK;
    end
    else
      s_reg <= s_next;
  end

  assign rd_data = s_reg.rdata;
  assign timer_output_pin = s_reg.pin;
  assign run_out = s_reg.running;
  assign match_overflow_irq = s_reg.mo_irq;
  assign capture0_irq = s_reg.c0_irq;
  assign capture1_irq = s_reg.c1_irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_stop_clears_count: assert property (!run_now |=> s_reg.cnt == 16'h0000)
    else $error("counter not cleared while stopped");

  a_overflow_wraps: assert property (ovf |=> s_reg.cnt == 16'h0000 && s_reg.st[`TCC_ST_OVF])
    else $error("overflow did not wrap or flag");

  a_overflow_irq: assert property ((ovf && !s_reg.mask[`TCC_ST_OVF]) |=> match_overflow_irq)
    else $error("overflow irq missing");

  a_match_irq: assert property ((match0 && !s_reg.mask[`TCC_ST_MATCH0]) |=> match_overflow_irq)
    else $error("match irq missing");

  a_dbuf_transfer: assert property ((s_reg.dbe && match1 && !wr_cmp0) |=> s_reg.cmp0 == $past(s_reg.buf0))
    else $error("buffer not transferred on compare 1 match");

  a_stopped_write: assert property ((wr_cmp1 && !run_now) |=> s_reg.cmp1 == $past(bus_req.wdata[15:0]))
    else $error("stopped write not immediate");

  a_soft_capture: assert property (soft_cap |=> s_reg.cap0 == $past(s_reg.cnt) && s_reg.st[`TCC_ST_CAP0])
    else $error("soft capture failed");

  a_neigh_capture: assert property ((s_reg.cpm == TCC_CPM_NEIGHBOUR && $fell(neighbour_flipflop_output))
    |=> s_reg.cap1 == $past(s_reg.cnt))
    else $error("falling-edge capture 1 failed");

  a_snapshot_read: assert property (hit(bus_req, `TCC_OFS_SNAP, 1'b0) |=> rd_data == {16'h0, $past(s_reg.cnt)})
    else $error("snapshot read wrong");

  a_force_set: assert property ((hit(bus_req, `TCC_OFS_FFCR, 1'b1) && bus_req.wdata[1:0] == 2'h1)
    |=> s_reg.ff ##0 timer_output_pin == s_reg.oe)
    else $error("force set failed");

  a_clear_on_match: assert property ((s_reg.cle && match1) |=> s_reg.cnt == 16'h0000)
    else $error("clear on match failed");

  a_status_clear: assert property ((hit(bus_req, `TCC_OFS_STATUS, 1'b0) && events == 5'h00) |=> s_reg.st == 5'h00)
    else $error("status read did not clear");

  // Interrupt and flag checks; masking only gates the request lines
  a_match1_irq: assert property ((match1 && !s_reg.mask[`TCC_ST_MATCH1]) |=> match_overflow_irq)
    else $error("match 1 irq missing");

  a_cap0_irq: assert property ((cap0_ev && !s_next.mask[`TCC_ST_CAP0]) |=> capture0_irq)
    else $error("capture 0 irq missing");

  a_cap1_irq: assert property ((cap1_ev && !s_next.mask[`TCC_ST_CAP1]) |=> capture1_irq)
    else $error("capture 1 irq missing");

  a_match0_flag: assert property (match0 |=> s_reg.st[`TCC_ST_MATCH0])
    else $error("match 0 flag missing");

  a_match1_flag: assert property (match1 |=> s_reg.st[`TCC_ST_MATCH1])
    else $error("match 1 flag missing");

  a_irq_masked: assert property ((s_next.st[2:0] & ~s_next.mask[2:0]) == 3'h0 |=> !match_overflow_irq)
    else $error("masked source raised irq");

  // Capture checks
  a_cap0_value: assert property (cap0_ev |=> s_reg.cap0 == $past(s_reg.cnt))
    else $error("capture 0 value wrong");

  a_cap1_value: assert property (cap1_ev |=> s_reg.cap1 == $past(s_reg.cnt))
    else $error("capture 1 value wrong");

  a_neigh_rise: assert property ((s_reg.cpm == TCC_CPM_NEIGHBOUR && $rose(neighbour_flipflop_output))
    |=> s_reg.cap0 == $past(s_reg.cnt))
    else $error("rising-edge capture 0 failed");

  // Counting checks
  a_ext0_count: assert property ((s_reg.src == TCC_SRC_EXT0 && run_now && rise(s_reg.in0_q, external_input_0)
    && !(s_reg.cle && match1)) |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001)
    else $error("event count step missing");

  a_idle_hold: assert property ((run_now && !tick) |=> s_reg.cnt == $past(s_reg.cnt))
    else $error("counter moved without a tick");

  a_div1_step: assert property ((run_now && s_reg.src == TCC_SRC_DIV1 && !(s_reg.cle && match1))
    |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001)
    else $error("divide 1 step missing");

  a_run_stop: assert property ((hit(bus_req, `TCC_OFS_RUN, 1'b1) && !bus_req.wdata[`TCC_RUN_COUNT_BIT]) |=> !run_out)
    else $error("run bit clear did not stop");

  a_sync_held: assert property ((s_reg.sync && !master_run_in) |=> s_reg.cnt == 16'h0000)
    else $error("slave counted without master");

  // Compare register checks
  a_direct_write: assert property ((wr_cmp0 && !s_reg.dbe) |=> s_reg.cmp0 == $past(bus_req.wdata[15:0]))
    else $error("unbuffered write not direct");

  a_buffered_hold: assert property ((wr_cmp0 && s_reg.dbe && run_now && !match1) |=> s_reg.cmp0 == $past(s_reg.cmp0))
    else $error("buffered write reached compare");

  a_dbuf_cmp1: assert property ((s_reg.dbe && match1 && !wr_cmp1) |=> s_reg.cmp1 == $past(s_reg.buf1))
    else $error("buffer 1 not transferred");

  a_stopped_write0: assert property ((wr_cmp0 && !run_now) |=> s_reg.cmp0 == $past(bus_req.wdata[15:0]))
    else $error("stopped write 0 not immediate");

  // Flip-flop and pin checks
  a_force_clear: assert property ((hit(bus_req, `TCC_OFS_FFCR, 1'b1) && bus_req.wdata[1:0] == 2'h2) |=> !s_reg.ff)
    else $error("force clear failed");

  a_force_invert: assert property ((hit(bus_req, `TCC_OFS_FFCR, 1'b1) && bus_req.wdata[1:0] == 2'h0)
    |=> s_reg.ff != $past(s_reg.ff))
    else $error("force invert failed");

  a_toggle_quiet: assert property (((tog_src & s_reg.ten) == 4'h0 && !hit(bus_req, `TCC_OFS_FFCR, 1'b1))
    |=> s_reg.ff == $past(s_reg.ff))
    else $error("flip-flop moved without source");

  a_match0_toggle: assert property ((tog_src == 4'h1 && s_reg.ten[0] && !hit(bus_req, `TCC_OFS_FFCR, 1'b1))
    |=> s_reg.ff != $past(s_reg.ff))
    else $error("match 0 toggle missing");

  a_pin_gated: assert property (!s_reg.oe |-> !timer_output_pin)
    else $error("pin driven while disabled");

  a_pin_follows: assert property (s_reg.oe |-> timer_output_pin == s_reg.ff)
    else $error("pin does not follow flip-flop");

  // Read data must not linger past its one cycle
  a_rd_idle: assert property (!bus_req.rd |=> rd_data == 32'h00000000)
    else $error("read data stood too long");

endmodule : tcc_channel

// >>> tcc_consts.svh
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register word offsets (byte addresses)
`define TCC_OFS_RUN    8'h00
`define TCC_OFS_CTRL   8'h04
`define TCC_OFS_MODE   8'h08
`define TCC_OFS_FFCR   8'h0C
`define TCC_OFS_STATUS 8'h10
`define TCC_OFS_MASK   8'h14
`define TCC_OFS_SNAP   8'h18
`define TCC_OFS_CMP0   8'h1C
`define TCC_OFS_CMP1   8'h20
`define TCC_OFS_CAP0   8'h24
`define TCC_OFS_CAP1   8'h28

// Run register fields
`define TCC_RUN_COUNT_BIT 0
`define TCC_RUN_PRE_BIT 2

// Control register fields
`define TCC_CTRL_DBE_BIT 0
`define TCC_CTRL_SYNC_BIT 1
`define TCC_CTRL_OE_BIT 2

// Mode register fields
`define TCC_MODE_SRC_LSB 0
`define TCC_MODE_CLE_BIT 2
`define TCC_MODE_CPM_LSB 3
`define TCC_MODE_SOFTCAP_BIT 5

// Flip-flop control fields
`define TCC_FFCR_FORCE_LSB 0
`define TCC_FFCR_TEN_LSB 2

// Status / mask bit positions
`define TCC_ST_MATCH0 0
`define TCC_ST_MATCH1 1
`define TCC_ST_OVF 2
`define TCC_ST_CAP0 3
`define TCC_ST_CAP1 4

// Reset values and counter maximum
`define TCC_RST_COUNT 16'h0000
`define TCC_RST_MASK 5'h00
`define TCC_CNT_MAX 16'hFFFF

`endif

// >>> tcc_pkg.sv
package tcc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_req_t;

  typedef enum logic [1:0] {
    TCC_SRC_EXT0 = 2'h0,
    TCC_SRC_DIV1 = 2'h1,
    TCC_SRC_DIV4 = 2'h2,
    TCC_SRC_DIV16 = 2'h3
  } tcc_src_t;

  typedef enum logic [1:0] {
    TCC_CPM_OFF = 2'h0,
    TCC_CPM_IN0_IN1 = 2'h1,
    TCC_CPM_IN0_BOTH = 2'h2,
    TCC_CPM_NEIGHBOUR = 2'h3
  } tcc_cpm_t;

  typedef enum logic [1:0] {
    TCC_FF_INVERT = 2'h0,
    TCC_FF_SET = 2'h1,
    TCC_FF_CLEAR = 2'h2,
    TCC_FF_KEEP = 2'h3
  } tcc_force_t;

  typedef struct packed {
    logic count_run;
    logic pre_run;
    logic running;
    logic dbe;
    logic sync;
    logic oe;
    tcc_src_t src;
    logic cle;
    tcc_cpm_t cpm;
    logic [3:0] ten;
    logic [4:0] st;
    logic [4:0] mask;
    logic [3:0] pre;
    logic [15:0] cnt;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] buf0;
    logic [15:0] buf1;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic [15:0] snap;
    logic ff;
    logic in0_q;
    logic in1_q;
    logic nb_q;
    logic [31:0] rdata;
    logic mo_irq;
    logic c0_irq;
    logic c1_irq;
    logic pin;
  } tcc_state_t;

endpackage : tcc_pkg

// >>> tcc_board.sv
`timescale 1ns/100ps

module tcc_board (
  // Clock
  input wire logic core_clk,
  // Pulse sources
  output logic ext0,
  output logic ext1,
  output logic nb,
  output logic master_run,
  // Output load
  input wire logic pin
);
  // All sources idle low; ext1 sits on a board pull-down
  initial
  begin
    ext0 = 1'b0;
    ext1 = 1'b0;
    nb = 1'b0;
    master_run = 1'b0;
  end

  // High level held two cycles, low three between pulses, so the synchronous edge detect sees it
  task automatic pulse_ext0(input int n);
    repeat (n)
    begin
      @(posedge core_clk) ext0 <= 1'b1;
      repeat (2) @(posedge core_clk);
      ext0 <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask : pulse_ext0

  task automatic pulse_ext1(input int n);
    repeat (n)
    begin
      @(posedge core_clk) ext1 <= 1'b1;
      repeat (2) @(posedge core_clk);
      ext1 <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask : pulse_ext1

  task automatic set_nb(input logic lv);
    @(posedge core_clk) nb <= lv;
    repeat (3) @(posedge core_clk);
  endtask : set_nb

  task automatic set_master(input logic lv);
    @(posedge core_clk) master_run <= lv;
  endtask : set_master
endmodule : tcc_board

// >>> tb_top.sv
`timescale 1ns/100ps
`include "tcc_consts.svh"

module tb_top
  import tcc_pkg::*;
  ;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcc_row_t;
  logic core_clk;
  logic rst;
  tcc_bus_req_t req;
  logic [31:0] rd_data;
  logic [31:0] v;
  logic ext0, ext1, nb, mrun, pin, run_o, mo_irq, c0_irq, c1_irq;
  int n_mismatch;
  int comparisons;
  int i;
  tcc_row_t rows[5] = '{'{`TCC_OFS_CMP0, 32'hABCD0004, 32'h4}, '{`TCC_OFS_CMP1, 32'h9, 32'h9},
    '{`TCC_OFS_MASK, 32'h1F, 32'h1F}, '{`TCC_OFS_MASK, 32'h0, 32'h0}, '{8'h3C, 32'hABCD, 32'h0}};
  logic [1:0] frc[6] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic fexp[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  tcc_channel dut (.core_clk(core_clk), .rst(rst), .bus_req(req), .rd_data(rd_data),
    .external_input_0(ext0), .external_input_1(ext1), .neighbour_flipflop_output(nb),
    .master_run_in(mrun), .timer_output_pin(pin), .run_out(run_o), .match_overflow_irq(mo_irq),
    .capture0_irq(c0_irq), .capture1_irq(c1_irq));

  tcc_board board (.core_clk(core_clk), .ext0(ext0), .ext1(ext1), .nb(nb), .master_run(mrun), .pin(pin));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk) req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #900_000;
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    req = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("outs", {mo_irq, c0_irq, c1_irq, run_o}, 0);
    rd(`TCC_OFS_CTRL, v);
    chk("ctrl", v, 0);
    for (i = 0; i < 5; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("row", v, rows[i].e);
    end
    // Interval run: cmp0 4 below cmp1 9, clear on cmp1 match
    wr(`TCC_OFS_MODE, 32'h25);
    wr(`TCC_OFS_RUN, 32'h5);
    repeat (40) @(posedge core_clk);
    chk("mo_irq", mo_irq, 1);
    rd(`TCC_OFS_SNAP, v);
    chk("wrap", v > 9, 0);
    rd(`TCC_OFS_STATUS, v);
    chk("st", v, 3);
    wr(`TCC_OFS_RUN, 32'h0);
    repeat (3) @(posedge core_clk);
    rd(`TCC_OFS_SNAP, v);
    chk("stop", v, 0);
    rd(`TCC_OFS_STATUS, v);
    rd(`TCC_OFS_STATUS, v);
    chk("st_clr", v, 0);
    // Buffered compare only moves on the cmp1 match
    wr(`TCC_OFS_CMP1, 32'hFF);
    wr(`TCC_OFS_CTRL, 32'h1);
    wr(`TCC_OFS_RUN, 32'h5);
    wr(`TCC_OFS_CMP0, 32'h50);
    rd(`TCC_OFS_CMP0, v);
    chk("buf_old", v, 32'h4);
    repeat (300) @(posedge core_clk);
    rd(`TCC_OFS_CMP0, v);
    chk("buf_new", v, 32'h50);
    wr(`TCC_OFS_RUN, 32'h0);
    // Event counting and captures
    wr(`TCC_OFS_MODE, 32'h20);
    wr(`TCC_OFS_RUN, 32'h5);
    board.pulse_ext0(5);
    rd(`TCC_OFS_SNAP, v);
    chk("events", v, 5);
    wr(`TCC_OFS_MODE, 32'h00);
    rd(`TCC_OFS_CAP0, v);
    chk("softcap", v, 5);
    wr(`TCC_OFS_MODE, 32'h38);
    wr(`TCC_OFS_FFCR, 32'h32);
    wr(`TCC_OFS_CTRL, 32'h4);
    rd(`TCC_OFS_STATUS, v);
    board.set_nb(1'b1);
    chk("c0_irq", c0_irq, 1);
    chk("pin_cap0", pin, 1);
    board.pulse_ext0(2);
    board.set_nb(1'b0);
    chk("c1_irq", c1_irq, 1);
    chk("pin_cap1", pin, 0);
    rd(`TCC_OFS_CAP0, v);
    chk("cap0", v, 5);
    rd(`TCC_OFS_CAP1, v);
    chk("cap1", v, 7);
    // Capture select 01: ext0 rise to cap0, ext1 rise to cap1
    wr(`TCC_OFS_MODE, 32'h28);
    board.pulse_ext0(1);
    board.pulse_ext1(1);
    rd(`TCC_OFS_CAP0, v);
    chk("cap0_m1", v, 7);
    rd(`TCC_OFS_CAP1, v);
    chk("cap1_m1", v, 8);
    // Capture select 10: ext0 rise to cap0, ext0 fall to cap1
    wr(`TCC_OFS_MODE, 32'h30);
    board.pulse_ext0(1);
    rd(`TCC_OFS_CAP0, v);
    chk("cap0_m2", v, 8);
    rd(`TCC_OFS_CAP1, v);
    chk("cap1_m2", v, 9);
    for (i = 0; i < 6; i++)
    begin
      wr(`TCC_OFS_FFCR, {30'h0, frc[i]});
      @(posedge core_clk);
      chk("force", pin, fexp[i]);
    end
    // Slave follows the master run line with its own run bits clear
    wr(`TCC_OFS_RUN, 32'h0);
    wr(`TCC_OFS_MODE, 32'h21);
    wr(`TCC_OFS_CTRL, 32'h2);
    board.set_master(1'b1);
    repeat (20) @(posedge core_clk);
    rd(`TCC_OFS_SNAP, v);
    chk("sync_run", v == 0, 0);
    board.set_master(1'b0);
    repeat (3) @(posedge core_clk);
    rd(`TCC_OFS_SNAP, v);
    chk("sync_stop", v, 0);
    // Free run through the full range
    wr(`TCC_OFS_CTRL, 32'h0);
    // Divide-by-4 tap: ten ticks in the forty cycles after the run write
    wr(`TCC_OFS_MODE, 32'h22);
    wr(`TCC_OFS_RUN, 32'h5);
    repeat (40) @(posedge core_clk);
    rd(`TCC_OFS_SNAP, v);
    chk("div4", v, 10);
    wr(`TCC_OFS_RUN, 32'h0);
    wr(`TCC_OFS_MODE, 32'h21);
    wr(`TCC_OFS_RUN, 32'h5);
    repeat (65545) @(posedge core_clk);
    chk("ovf_irq", mo_irq, 1);
    rd(`TCC_OFS_STATUS, v);
    chk("ovf", v & 32'h4, 32'h4);
    tally_and_finish();
  end
endmodule : tb_top
